// file: hdl/gp_pkg.sv
// Package of constants and types for the group 0 and group 1 port block.
// What this block does
// - Any reset returns every port to default with input and output buffers off, except group 0 pin 0, which drives TDO.
// - During sleep all I/O port directions, enables and levels hold; group 1 peripheral pins and the test port follow their drivers.
// - Groups 9 and 10 each get a gate bit apart from the shared gate.
// - Debug pin low turns group 0 into the test port TDO, TDI, TMS, TCK.
// - Debug pin high makes group 0 plain I/O under its enable registers.
// - Bit 3 of power control one gates groups 0 to 8 off, except group 0 while the debug pin is low.
// - The shared gate leaves group 1 pins on special functions working.
// - Group 0 wake select enables group 0 pins 2 and 3 as wake inputs while the debug pin is high.
// - Each group 1 pin role comes from its select; only I/O uses output enables.
// - Group 1 pins 3 and 4 wake on an edge with levels held 4 oscillator ticks.
// - Group 0 output enable bits 3..0, zero drives, reset to ones.
// - Group 0 input enable bits 3..0, one enables, reset to zeros.
// - Group 0 output data bits 3..0 drive enabled pins, reset to ones.
// - Group 0 input data bits 3..0 show sampled pin levels, reset zero.
// - Group 1 output enable bits 4..0, zero drives, reset to ones.
// - Group 1 input enable bits 4..0, one enables, reset to zeros.
// - Group 1 output data bits 4..0 drive enabled pins, reset to ones.
// - Group 1 input data shows pin levels whenever input on, any function, except gated I/O pins.
// - Function select code zero means general I/O, others are peripherals.
package gp_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses.
  // ----------------------------------------------------------------
  localparam logic [15:0] G0_OE_ADDR  = 16'h28a8;
  localparam logic [15:0] G0_IE_ADDR  = 16'h28a9;
  localparam logic [15:0] G0_OD_ADDR  = 16'h28aa;
  localparam logic [15:0] G0_ID_ADDR  = 16'h28ab;
  localparam logic [15:0] G1_OE_ADDR  = 16'h28ac;
  localparam logic [15:0] G1_IE_ADDR  = 16'h28ad;
  localparam logic [15:0] G1_OD_ADDR  = 16'h28ae;
  localparam logic [15:0] G1_ID_ADDR  = 16'h28af;
  localparam logic [15:0] G1_FS_ADDR0 = 16'h28c4;
  localparam logic [15:0] PWR_ADDR    = 16'h2d00;
  localparam logic [15:0] WAKE_ADDR   = 16'h00c9;
  localparam logic [15:0] STAT_ADDR   = 16'h2d04;
  localparam int          ADDR_W      = 16;

  // ----------------------------------------------------------------
  // Field positions, widths and reset values.
  // ----------------------------------------------------------------
  localparam int          G0_N        = 4;
  localparam int          G1_N        = 5;
  localparam int          FS_W        = 3;
  localparam int          PWR_SHARED  = 3;
  localparam int          PWR_G9      = 4;
  localparam int          PWR_G10     = 5;
  localparam int          WAKE_G0_SEL = 1;
  localparam logic [2:0]  FS_GPIO     = 3'h0;
  localparam logic [3:0]  G0_OE_RST   = 4'hf;
  localparam logic [3:0]  G0_IE_RST   = 4'h0;
  localparam logic [3:0]  G0_OD_RST   = 4'hf;
  localparam logic [4:0]  G1_OE_RST   = 5'h1f;
  localparam logic [4:0]  G1_IE_RST   = 5'h00;
  localparam logic [4:0]  G1_OD_RST   = 5'h1f;
  localparam logic [7:0]  PWR_RST     = 8'h00;
  localparam logic [7:0]  WAKE_RST    = 8'h00;
  localparam logic [2:0]  WAKE_HOLD   = 3'h4;

  // Signals of the test access port.
  typedef struct packed {
    logic tdo;
    logic tdi;
    logic tms;
    logic tck;
  } gp_jtag_s;

  // Pin group: level out, output enable.
  typedef struct packed {
    logic [G1_N-1:0] o;
    logic [G1_N-1:0] oe;
  } gp_pin_drv_s;

endpackage

// file: hdl/gp_ports.sv
// Group 0 and group 1 port logic with an AHB-Lite register slave.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module gp_ports (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                oscillator_clock,
  input  wire logic                debug_select_pin,
  input  wire logic                sleep_req,
  input  wire logic [3:0]          g0_pin_in,
  output logic [3:0]               g0_pin_out,
  output logic [3:0]               g0_pin_oe,
  input  wire logic [4:0]          g1_pin_in,
  output logic [4:0]               g1_pin_out,
  output logic [4:0]               g1_pin_oe,
  input  wire gp_pkg::gp_pin_drv_s g1_spec_drv,
  output logic [4:0]               g1_spec_in,
  input  wire logic                jtag_tdo,
  output gp_pkg::gp_jtag_s         jtag_in,
  output logic                     gate_low_groups,
  output logic                     gate_group9,
  output logic                     gate_group10,
  output logic                     wake_event
);

  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [3:0]  g0_oe_r, g0_ie_r, g0_od_r, g0_id_r;
  logic [4:0]  g1_oe_r, g1_ie_r, g1_od_r, g1_id_r;
  logic [2:0]  g1_fs_r [5];
  logic [7:0]  pwr_r, wake_r;
  logic        sleep_r;
  logic        wr_pend_r;
  logic [15:0] wr_addr_r;

  // Pin synchronisers: first stage feeds only the second.
  logic [3:0] g0_s1_r, g0_s2_r;
  logic [4:0] g1_s1_r, g1_s2_r;
  logic       osc_s1_r, osc_s2_r, osc_s3_r, dbg_s1_r, dbg_s2_r, slp_s1_r, slp_s2_r;

  // Synchronise pin levels, debug pin, sleep request and oscillator clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {g0_s1_r, g0_s2_r} <= '0;
      {g1_s1_r, g1_s2_r} <= '0;
      {osc_s1_r, osc_s2_r, osc_s3_r} <= '0;
      {dbg_s1_r, dbg_s2_r, slp_s1_r, slp_s2_r} <= 4'h0;
    end else begin
      g0_s1_r  <= g0_pin_in;
      g0_s2_r  <= g0_s1_r;
      g1_s1_r  <= g1_pin_in;
      g1_s2_r  <= g1_s1_r;
      osc_s1_r <= oscillator_clock;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      dbg_s1_r <= debug_select_pin;
      dbg_s2_r <= dbg_s1_r;
      slp_s1_r <= sleep_req;
      slp_s2_r <= slp_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, writes land at the data phase.
  // ----------------------------------------------------------------
  // True when an address falls on one of the five group 1 select bytes.
  function automatic logic fs_range(input logic [15:0] a);
    return (a >= gp_pkg::G1_FS_ADDR0) && (a < gp_pkg::G1_FS_ADDR0 + 16'h0005);
  endfunction

  wire        take    = hsel & hready & htrans[1];
  wire [15:0] a_addr  = haddr[15:0];
  wire        do_wr   = wr_pend_r & ~sleep_r;
  wire        fs_hit  = fs_range(wr_addr_r);
  wire [2:0]  fs_idx  = 3'(wr_addr_r - gp_pkg::G1_FS_ADDR0);
  wire [2:0]  rd_idx  = 3'(a_addr - gp_pkg::G1_FS_ADDR0);
  wire        rd_fs   = fs_range(a_addr);

  // Address phase capture of write requests.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 16'h0000;
    end else begin
      wr_pend_r <= take & hwrite;
      wr_addr_r <= a_addr;
    end
  end

  // Read data is registered at the address phase edge.
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (a_addr)
      gp_pkg::G0_OE_ADDR: rd_nxt[3:0] = g0_oe_r;
      gp_pkg::G0_IE_ADDR: rd_nxt[3:0] = g0_ie_r;
      gp_pkg::G0_OD_ADDR: rd_nxt[3:0] = g0_od_r;
      gp_pkg::G0_ID_ADDR: rd_nxt[3:0] = g0_id_r;
      gp_pkg::G1_OE_ADDR: rd_nxt[4:0] = g1_oe_r;
      gp_pkg::G1_IE_ADDR: rd_nxt[4:0] = g1_ie_r;
      gp_pkg::G1_OD_ADDR: rd_nxt[4:0] = g1_od_r;
      gp_pkg::G1_ID_ADDR: rd_nxt[4:0] = g1_id_r;
      gp_pkg::PWR_ADDR:   rd_nxt[7:0] = pwr_r;
      gp_pkg::WAKE_ADDR:  rd_nxt[7:0] = wake_r;
      gp_pkg::STAT_ADDR:  rd_nxt[2:0] = {wake_event, sleep_r, dbg_s2_r};
      default:            rd_nxt[2:0] = rd_fs ? g1_fs_r[rd_idx] : 3'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (take && !hwrite) hrdata <= rd_nxt;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Configuration registers, held frozen while asleep.
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g0_oe_r <= gp_pkg::G0_OE_RST;
      g0_ie_r <= gp_pkg::G0_IE_RST;
      g0_od_r <= gp_pkg::G0_OD_RST;
      g1_oe_r <= gp_pkg::G1_OE_RST;
      g1_ie_r <= gp_pkg::G1_IE_RST;
      g1_od_r <= gp_pkg::G1_OD_RST;
      pwr_r   <= gp_pkg::PWR_RST;
      wake_r  <= gp_pkg::WAKE_RST;
      for (int i = 0; i < 5; i++) g1_fs_r[i] <= gp_pkg::FS_GPIO;
    end else if (do_wr) begin
      case (wr_addr_r)
        gp_pkg::G0_OE_ADDR: g0_oe_r <= hwdata[3:0];
        gp_pkg::G0_IE_ADDR: g0_ie_r <= hwdata[3:0];
        gp_pkg::G0_OD_ADDR: g0_od_r <= hwdata[3:0];
        gp_pkg::G1_OE_ADDR: g1_oe_r <= hwdata[4:0];
        gp_pkg::G1_IE_ADDR: g1_ie_r <= hwdata[4:0];
        gp_pkg::G1_OD_ADDR: g1_od_r <= hwdata[4:0];
        gp_pkg::PWR_ADDR:   pwr_r   <= hwdata[7:0];
        gp_pkg::WAKE_ADDR:  wake_r  <= hwdata[7:0];
        default: if (fs_hit) g1_fs_r[fs_idx] <= hwdata[2:0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin muxing, gating and input sampling.
  // ----------------------------------------------------------------
  wire       jtag_mode = ~dbg_s2_r;
  wire       gate_low  = pwr_r[gp_pkg::PWR_SHARED];
  wire [4:0] g1_gpio;

  // Group 0: test port when debug pin low, gated I/O otherwise.
  assign g0_pin_oe  = jtag_mode ? 4'h1 : (gate_low ? 4'h0 : ~g0_oe_r);
  assign g0_pin_out = jtag_mode ? {3'h0, jtag_tdo} : g0_od_r;
  assign jtag_in    = '{tdo: jtag_tdo, tdi: g0_s2_r[1], tms: g0_s2_r[2], tck: g0_s2_r[3]};

  // Group 1: function select picks I/O or peripheral; gate spares peripherals.
  for (genvar p = 0; p < 5; p++) begin : g_g1
    assign g1_gpio[p]    = (g1_fs_r[p] == gp_pkg::FS_GPIO);
    assign g1_pin_oe[p]  = g1_gpio[p] ? (~gate_low & ~g1_oe_r[p]) : g1_spec_drv.oe[p];
    assign g1_pin_out[p] = g1_gpio[p] ? g1_od_r[p] : g1_spec_drv.o[p];
    assign g1_spec_in[p] = g1_gpio[p] ? 1'b0 : g1_s2_r[p];
  end

  assign gate_low_groups = gate_low;
  assign gate_group9     = pwr_r[gp_pkg::PWR_G9];
  assign gate_group10    = pwr_r[gp_pkg::PWR_G10];

  // Input data follows pins only where input is on and not gated.
  wire [3:0] g0_ien = jtag_mode ? 4'h0 : (gate_low ? 4'h0 : g0_ie_r);
  wire [4:0] g1_ien = g1_ie_r & ~(g1_gpio & {5{gate_low}});
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g0_id_r <= 4'h0;
      g1_id_r <= 5'h00;
    end else begin
      g0_id_r <= (g0_s2_r & g0_ien) | (g0_id_r & ~g0_ien);
      g1_id_r <= (g1_s2_r & g1_ien) | (g1_id_r & ~g1_ien);
    end
  end

  // ----------------------------------------------------------------
  // Sleep latch and pin wakeup with hold filter on oscillator ticks.
  // ----------------------------------------------------------------
  wire osc_tick = osc_s2_r & ~osc_s3_r;
  wire [3:0] wk_en = {g1_ie_r[4:3],
                      {2{wake_r[gp_pkg::WAKE_G0_SEL]}} & ~{2{jtag_mode}}};
  wire [3:0] wk_lvl = {g1_s2_r[4:3], g0_s2_r[3:2]};
  logic [3:0] wk_stable_r;
  logic [2:0] wk_cnt_r [4];
  logic [3:0] wk_hit;

  // Per pin: a level is stable after the hold count of oscillator ticks.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wk_stable_r <= 4'h0;
      for (int i = 0; i < 4; i++) wk_cnt_r[i] <= 3'h0;
    end else if (osc_tick) begin
      for (int i = 0; i < 4; i++) begin
        if (wk_lvl[i] != wk_stable_r[i]) begin
          if (wk_cnt_r[i] >= gp_pkg::WAKE_HOLD - 3'h1) begin
            wk_stable_r[i] <= wk_lvl[i];
            wk_cnt_r[i]    <= 3'h0;
          end else begin
            wk_cnt_r[i] <= wk_cnt_r[i] + 3'h1;
          end
        end else begin
          wk_cnt_r[i] <= 3'h0;
        end
      end
    end
  end

  // Accepted edge: old level was stable and new level held long enough.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wk_hit[i] = osc_tick && wk_en[i] && (wk_lvl[i] != wk_stable_r[i]) &&
                  (wk_cnt_r[i] >= gp_pkg::WAKE_HOLD - 3'h1);
    end
  end

  // Sleep entry from request; a filtered edge wakes the system.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_r    <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      wake_event <= sleep_r & (|wk_hit);
      if (sleep_r && |wk_hit) sleep_r <= 1'b0;
      else if (slp_s2_r) sleep_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  a_sleep_holds_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_r && $past(sleep_r) |-> $stable(g0_oe_r) && $stable(g1_od_r))
    else $error("Configuration changed during sleep.");
  a_jtag_tdo_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    !dbg_s2_r |-> g0_pin_oe == 4'h1 && g0_pin_out[0] == jtag_tdo)
    else $error("Test port not driving TDO.");
  a_gate_off_g0: assert property (@(posedge hclk) disable iff (!hresetn)
    dbg_s2_r && gate_low |-> g0_pin_oe == 4'h0)
    else $error("Gated group 0 still drives.");
  a_spec_survive: assert property (@(posedge hclk) disable iff (!hresetn)
    g1_fs_r[0] != 3'h0 |-> g1_pin_oe[0] == g1_spec_drv.oe[0])
    else $error("Special function disturbed.");
  a_gpio_oe_g1: assert property (@(posedge hclk) disable iff (!hresetn)
    g1_fs_r[1] == 3'h0 && !gate_low |-> g1_pin_oe[1] == !g1_oe_r[1])
    else $error("Group 1 drive enable wrong.");
  a_id_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(g1_ien[2]) |-> g1_id_r[2] == $past(g1_id_r[2]))
    else $error("Disabled input data moved.");
  a_id_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(g0_ien[0]) |-> g0_id_r[0] == $past(g0_s2_r[0]))
    else $error("Input data not sampled.");
  a_wake_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_event |-> !sleep_r && $past(sleep_r) && $past(|wk_en))
    else $error("Wake without enabled pin in sleep.");
  a_reset_defaults: assert property (@(posedge hclk)
    $rose(hresetn) |-> g0_oe_r == 4'hf && g1_ie_r == 5'h00)
    else $error("Reset defaults wrong.");
  // Further reset values of the output side.
  a_reset_more: assert property (@(posedge hclk)
    $rose(hresetn) |-> g0_od_r == gp_pkg::G0_OD_RST && g1_oe_r == gp_pkg::G1_OE_RST)
    else $error("Output reset values wrong.");
  // Input data starts cleared after reset.
  a_reset_ids: assert property (@(posedge hclk)
    $rose(hresetn) |-> g0_id_r == 4'h0 && g1_id_r == 5'h00)
    else $error("Input data reset wrong.");
  // Enables and data hold while asleep.
  a_sleep_holds_rest: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_r && $past(sleep_r) |-> $stable(g0_od_r) && $stable(g1_oe_r) && $stable(g1_ie_r))
    else $error("Port state changed during sleep.");
  // Power, wake and group 0 input enable settings hold while asleep.
  a_sleep_holds_pwr: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_r && $past(sleep_r) |-> $stable(pwr_r) && $stable(wake_r) && $stable(g0_ie_r))
    else $error("Power settings changed during sleep.");
  // Group 0 in plain I/O mode follows its output enables.
  a_gpio_oe_g0: assert property (@(posedge hclk) disable iff (!hresetn)
    dbg_s2_r && !gate_low |-> g0_pin_oe == ~g0_oe_r)
    else $error("Group 0 drive enable wrong.");
  // Group 0 in plain I/O mode drives its output data.
  a_gpio_out_g0: assert property (@(posedge hclk) disable iff (!hresetn)
    dbg_s2_r |-> g0_pin_out == g0_od_r)
    else $error("Group 0 output data wrong.");
  // Test port inputs come from the synchronised pins.
  a_jtag_in_sync: assert property (@(posedge hclk) disable iff (!hresetn)
    !dbg_s2_r |-> jtag_in.tdi == $past(g0_s1_r[1]) && jtag_in.tck == $past(g0_s1_r[3]))
    else $error("Test port input wrong.");
  // No group 0 wake while the test port owns the pins.
  a_jtag_no_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    !dbg_s2_r |-> wk_hit[1:0] == 2'h0)
    else $error("Wake from test port pins.");
  // Group 0 wake needs its select bit.
  a_g0_sel_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !wake_r[gp_pkg::WAKE_G0_SEL] |-> wk_hit[1:0] == 2'h0)
    else $error("Group 0 wake without select.");
  // A filtered edge in sleep wakes and pulses.
  a_wake_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_r && (|wk_hit) |=> wake_event && !sleep_r)
    else $error("Filtered edge did not wake.");
  // No wake pulse while awake.
  a_wake_no_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    !sleep_r |=> !wake_event)
    else $error("Wake pulse while awake.");
  // A group 1 pin without input enable never wakes.
  a_wake_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    !wk_en[2] |-> !wk_hit[2])
    else $error("Disabled pin woke.");
  // The hold counter never passes the hold count.
  a_wk_cnt_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    wk_cnt_r[2] < gp_pkg::WAKE_HOLD)
    else $error("Hold counter overran.");
  // A write lands in the group 0 output enables.
  a_write_oe0: assert property (@(posedge hclk) disable iff (!hresetn)
    do_wr && wr_addr_r == gp_pkg::G0_OE_ADDR |=> g0_oe_r == $past(hwdata[3:0]))
    else $error("Group 0 enable write lost.");
  // A write lands in the group 0 output data.
  a_write_od0: assert property (@(posedge hclk) disable iff (!hresetn)
    do_wr && wr_addr_r == gp_pkg::G0_OD_ADDR |=> g0_od_r == $past(hwdata[3:0]))
    else $error("Group 0 data write lost.");
  // A write lands in the group 1 input enables.
  a_write_ie1: assert property (@(posedge hclk) disable iff (!hresetn)
    do_wr && wr_addr_r == gp_pkg::G1_IE_ADDR |=> g1_ie_r == $past(hwdata[4:0]))
    else $error("Group 1 input enable write lost.");
  // A read returns the group 1 output data.
  a_read_od1: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && a_addr == gp_pkg::G1_OD_ADDR |=> hrdata[4:0] == $past(g1_od_r))
    else $error("Group 1 data read wrong.");
  // The shared gate turns off a group 1 I/O driver.
  a_gated_g1_off: assert property (@(posedge hclk) disable iff (!hresetn)
    g1_gpio[0] && gate_low |-> !g1_pin_oe[0])
    else $error("Gated group 1 still drives.");
  // A peripheral pin drives the peripheral level.
  a_spec_out_g1: assert property (@(posedge hclk) disable iff (!hresetn)
    !g1_gpio[2] |-> g1_pin_out[2] == g1_spec_drv.o[2])
    else $error("Peripheral level not driven.");
  // A peripheral pin passes its level to the peripheral.
  a_spec_in_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    g1_fs_r[1] != gp_pkg::FS_GPIO |-> g1_spec_in[1] == $past(g1_s1_r[1]))
    else $error("Peripheral input wrong.");
  // An I/O pin drives its output data.
  a_gpio_out_g1: assert property (@(posedge hclk) disable iff (!hresetn)
    g1_gpio[3] |-> g1_pin_out[3] == g1_od_r[3])
    else $error("Group 1 output data wrong.");
  // Code zero keeps the peripheral input quiet.
  a_spec_in_gpio: assert property (@(posedge hclk) disable iff (!hresetn)
    g1_fs_r[4] == gp_pkg::FS_GPIO |-> !g1_spec_in[4])
    else $error("I/O pin fed a peripheral.");
  // Disabled group 0 input data stays put.
  a_id_frozen_g0: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(g0_ien[1]) |-> g0_id_r[1] == $past(g0_id_r[1]))
    else $error("Disabled group 0 data moved.");
  // Enabled group 1 input data follows the pin.
  a_id_follow_g1: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(g1_ien[0]) |-> g1_id_r[0] == $past(g1_s2_r[0]))
    else $error("Group 1 input not sampled.");
  // The shared gate output follows its bit.
  a_gate_shared: assert property (@(posedge hclk) disable iff (!hresetn)
    gate_low_groups == pwr_r[gp_pkg::PWR_SHARED])
    else $error("Shared gate wrong.");
  // The group 9 gate follows its own bit.
  a_gate_g9_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    gate_group9 == pwr_r[gp_pkg::PWR_G9])
    else $error("Group 9 gate wrong.");
  // The group 10 gate follows its own bit.
  a_gate_g10_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    gate_group10 == pwr_r[gp_pkg::PWR_G10])
    else $error("Group 10 gate wrong.");

endmodule

// file: tb/gp_pins_model.sv
// Board model that resolves each port pin from the device drive and the board drive.
`timescale 1ns/10ps
module gp_pins_model (
  input  wire logic [3:0] g0_out,
  input  wire logic [3:0] g0_oe,
  input  wire logic [4:0] g1_out,
  input  wire logic [4:0] g1_oe,
  input  wire logic [3:0] g0_ext,
  input  wire logic [4:0] g1_ext,
  output logic [3:0]      g0_lvl,
  output logic [4:0]      g1_lvl
);
  // A driven pin shows the device level, otherwise the board level.
  assign g0_lvl = (g0_oe & g0_out) | (~g0_oe & g0_ext);
  assign g1_lvl = (g1_oe & g1_out) | (~g1_oe & g1_ext);
endmodule

// file: tb/gp_ports_tb.sv
// Self-checking testbench for the group 0 and group 1 port block.
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module gp_ports_tb;
  logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic                sleep_req, debug_select_pin, jtag_tdo, wake_event, woke;
  logic                gate_low_groups, gate_group9, gate_group10;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [1:0]          htrans;
  logic [2:0]          hsize, osc_div;
  logic [3:0]          g0_pin_in, g0_pin_out, g0_pin_oe, g0_ext, keep;
  logic [4:0]          g1_pin_in, g1_pin_out, g1_pin_oe, g1_ext, g1_spec_in, v;
  gp_pkg::gp_pin_drv_s g1_spec_drv;
  gp_pkg::gp_jtag_s    jtag_in;
  int                  error_cnt, n_checks, k;

  assign hready = hreadyout;

  gp_ports gp_ports_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .oscillator_clock(osc_div[2]),
    .debug_select_pin(debug_select_pin), .sleep_req(sleep_req), .g0_pin_in(g0_pin_in),
    .g0_pin_out(g0_pin_out), .g0_pin_oe(g0_pin_oe), .g1_pin_in(g1_pin_in),
    .g1_pin_out(g1_pin_out), .g1_pin_oe(g1_pin_oe), .g1_spec_drv(g1_spec_drv),
    .g1_spec_in(g1_spec_in), .jtag_tdo(jtag_tdo), .jtag_in(jtag_in),
    .gate_low_groups(gate_low_groups), .gate_group9(gate_group9),
    .gate_group10(gate_group10), .wake_event(wake_event));

  gp_pins_model gp_pins_model_inst (.g0_out(g0_pin_out), .g0_oe(g0_pin_oe),
    .g1_out(g1_pin_out), .g1_oe(g1_pin_oe), .g0_ext(g0_ext), .g1_ext(g1_ext),
    .g0_lvl(g0_pin_in), .g1_lvl(g1_pin_in));

  // The clock runs at 100 MHz and the oscillator ticks once every eight cycles.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) osc_div <= osc_div + 3'h1;

  // ------------------------------------------------------------
  // Bus and check helpers.
  // ------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Waits a few edges, then lets the edge updates settle.
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // Waits for ready under a bound; a hang is a mismatch.
  task automatic wait_rdy();
    int i;
    i = 0;
    do @(posedge hclk); while (hready !== 1'b1 && ++i < 50);
    if (i >= 50) begin
      error_cnt++;
      results();
    end
  endtask

  // One single word transfer; read data taken at the data phase edge.
  task automatic ahb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {16'h0000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    #1;
  endtask

  // Reads a register and compares it with the expected word.
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Polls for the wake pulse over a bounded number of cycles.
  task automatic wait_wake(input int n);
    woke = 1'b0;
    repeat (n) begin
      cyc(1);
      if (wake_event === 1'b1) woke = 1'b1;
    end
  endtask

  // Expected group 1 drive enables for one pin on a peripheral.
  function automatic logic [4:0] exp_oe(int p, logic [4:0] oe_r, logic [4:0] sp, logic g);
    logic [4:0] e;
    e = g ? 5'h00 : ~oe_r;
    e[p] = sp[p];
    return e;
  endfunction

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    {hsel, hwrite, sleep_req, debug_select_pin, jtag_tdo} = '0;
    {haddr, hwdata, htrans, hsize, osc_div, g1_ext, g1_spec_drv} = '0;
    hresetn = 1'b0;
    void'($urandom(12714));
    g0_ext = 4'($urandom);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
    rdc(gp_pkg::G0_OE_ADDR, 32'hf);
    rdc(gp_pkg::G0_IE_ADDR, 32'h0);
    rdc(gp_pkg::G0_OD_ADDR, 32'hf);
    rdc(gp_pkg::G0_ID_ADDR, 32'h0);
    rdc(gp_pkg::G1_OE_ADDR, 32'h1f);
    rdc(gp_pkg::G1_IE_ADDR, 32'h0);
    rdc(gp_pkg::G1_ID_ADDR, 32'h0);
    rdc(16'h28b0, 32'h0);
    // Test port mode while the debug pin is low.
    jtag_tdo <= 1'b1;
    cyc(4);
    `CHK(g0_pin_oe, 4'h1)
    `CHK(g0_pin_out[0], jtag_tdo)
    `CHK(jtag_in.tdo, 1'b1)
    `CHK({jtag_in.tdi, jtag_in.tms, jtag_in.tck}, {g0_ext[1], g0_ext[2], g0_ext[3]})
    // Plain I/O on group 0.
    debug_select_pin <= 1'b1;
    cyc(3);
    v = 5'($urandom);
    ahb(1'b1, gp_pkg::G0_OD_ADDR, {28'h0, v[3:0]});
    ahb(1'b1, gp_pkg::G0_OE_ADDR, 32'h0);
    cyc(1);
    `CHK(g0_pin_oe, 4'hf)
    `CHK(g0_pin_out, v[3:0])
    ahb(1'b1, gp_pkg::G0_OE_ADDR, 32'hf);
    ahb(1'b1, gp_pkg::G0_IE_ADDR, 32'hf);
    g0_ext <= 4'($urandom);
    cyc(4);
    keep = g0_ext;
    rdc(gp_pkg::G0_ID_ADDR, {28'h0, keep});
    ahb(1'b1, gp_pkg::G0_IE_ADDR, 32'h0);
    g0_ext <= ~g0_ext;
    cyc(4);
    rdc(gp_pkg::G0_ID_ADDR, {28'h0, keep});
    // Group 1 selects at random, shared gate on every other pass.
    for (int it = 0; it < 6; it++) begin
      k = $urandom_range(4, 0);
      v = 5'($urandom);
      ahb(1'b1, gp_pkg::G1_FS_ADDR0 + 16'(k), 32'($urandom_range(7, 1)));
      ahb(1'b1, gp_pkg::G1_OE_ADDR, {27'h0, v});
      ahb(1'b1, gp_pkg::PWR_ADDR, {28'h0, it[0], 3'h0});
      g1_spec_drv <= 10'($urandom);
      cyc(2);
      `CHK(gate_low_groups, it[0])
      `CHK(g1_pin_oe, exp_oe(k, v, g1_spec_drv.oe, it[0]))
      `CHK(g1_pin_out[k], g1_spec_drv.o[k])
      `CHK(g1_spec_in[k], g1_spec_drv.oe[k] & g1_spec_drv.o[k])
      ahb(1'b1, gp_pkg::G1_FS_ADDR0 + 16'(k), 32'h0);
    end
    ahb(1'b1, gp_pkg::PWR_ADDR, 32'h30);
    cyc(1);
    `CHK({gate_group10, gate_group9, gate_low_groups}, 3'h6)
    // Sleep, hold of state, glitch rejection and wake.
    ahb(1'b1, gp_pkg::PWR_ADDR, 32'h0);
    ahb(1'b1, gp_pkg::G1_OE_ADDR, 32'h1f);
    ahb(1'b1, gp_pkg::G1_IE_ADDR, 32'h08);
    ahb(1'b1, gp_pkg::WAKE_ADDR, 32'h2);
    cyc(40);
    sleep_req <= 1'b1;
    cyc(4);
    ahb(1'b1, gp_pkg::G1_OD_ADDR, 32'h0);
    rdc(gp_pkg::G1_OD_ADDR, 32'h1f);
    g1_ext[3] <= 1'b1;
    cyc(2);
    g1_ext[3] <= 1'b0;
    wait_wake(80);
    `CHK(woke, 1'b0)
    g1_ext[3] <= 1'b1;
    wait_wake(80);
    `CHK(woke, 1'b1)
    g0_ext[2] <= ~g0_ext[2];
    wait_wake(80);
    `CHK(woke, 1'b1)
    sleep_req <= 1'b0;
    // A second reset in mid-run.
    hresetn <= 1'b0;
    cyc(2);
    `CHK(g1_pin_oe, 5'h00)
    hresetn <= 1'b1;
    cyc(3);
    rdc(gp_pkg::G1_OD_ADDR, 32'h1f);
    results();
  end
endmodule
